/* File: verilog/agu_pkg.sv */
// Shared types and constants of the operand address generator.
// Assumes a 16-bit data path and a sixteen-entry working register file.
package agu_pkg;

	// ------------------------------------------------------------------
	// Widths and constants
	// ------------------------------------------------------------------
	localparam int          DATA_W    = 16;    // Data and address width.
	localparam int          NREG      = 16;    // Working registers.
	localparam int          HOLD_W    = 14;    // Hold count literal width.
	localparam logic [15:0] REG_RST   = 16'h0000; // Register reset value.
	localparam logic [3:0]  X_BASE    = 4'h8;  // First X-routed pointer.
	localparam logic [3:0]  Y_BASE    = 4'hA;  // First Y-routed pointer.
	localparam logic [4:0]  MAC_STEP2 = 5'h02; // Dual-source step sizes.
	localparam logic [4:0]  MAC_STEP4 = 5'h04;
	localparam logic [4:0]  MAC_STEP6 = 5'h06;

	// ------------------------------------------------------------------
	// Enumerations
	// ------------------------------------------------------------------
	// Operand addressing modes, one-hot.
	typedef enum logic [7:0] {
		M_FILE = 8'h01, // Address taken from the instruction.
		M_REG  = 8'h02, // Working register is the operand.
		M_IND  = 8'h04, // Pointer value is the address.
		M_POST = 8'h08, // Pointer used, then stepped.
		M_PRE  = 8'h10, // Pointer stepped, then used.
		M_IDX  = 8'h20, // Pointer plus offset register.
		M_LIT  = 8'h40, // Pointer plus instruction literal.
		M_IMPL = 8'h80  // Location implied by the opcode.
	} mode_t;

	// Instruction classes, one-hot.
	typedef enum logic [5:0] {
		C_ORD  = 6'h01, // Ordinary instruction.
		C_MOVE = 6'h02, // Move instruction.
		C_ACC  = 6'h04, // Accumulator class.
		C_MAC  = 6'h08, // Dual-source multiply-accumulate class.
		C_BRA  = 6'h10, // Branch instruction.
		C_HOLD = 6'h20  // Interrupt hold instruction.
	} cls_t;

	// ------------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------------
	// One operand of an ordinary, move or accumulator instruction.
	typedef struct packed {
		mode_t             mode;
		logic [3:0]        ptr;
		logic signed [4:0] amt;
	} opnd_t;

	// One side of a dual-source instruction.
	typedef struct packed {
		logic              en;
		logic              sel_b; // Second pointer of the pair.
		mode_t             mode;
		logic signed [4:0] amt;
	} mac_opnd_t;

	// Decoded instruction request.
	typedef struct packed {
		logic        valid;
		cls_t        cls;
		opnd_t       src;
		opnd_t       dst;
		mac_opnd_t   mx;
		mac_opnd_t   my;
		logic [3:0]  off_sel; // Shared offset register field.
		logic [15:0] lit;
		logic [15:0] wdata;
	} req_t;

	// Memory access request.
	typedef struct packed {
		logic        en;
		logic [15:0] ea;
	} mem_t;

	// Circular buffer configuration.
	typedef struct packed {
		logic        en;
		logic [3:0]  ptr;
		logic [15:0] start;
		logic [15:0] last;
	} mod_cfg_t;

	// Result of one operand address calculation.
	typedef struct packed {
		logic        mem;
		logic        upd;
		logic [15:0] ea;
		logic [15:0] newp;
	} calc_t;

endpackage

/* File: verilog/modulo_wrap.sv */
// Circular buffer wrap of an updated pointer value.
// Assumes start <= last; last is the final byte of the buffer.
module modulo_wrap (
	input  wire logic        en_i,
	input  wire logic [15:0] val_i,
	input  wire logic [15:0] start_i,
	input  wire logic [15:0] last_i,
	output logic      [15:0] val_o
);

	// ------------------------------------------------------------------
	// Wrap logic
	// ------------------------------------------------------------------
	logic [15:0] len; // Buffer length in bytes.

	// A step past either end folds back by one buffer length.
	always_comb begin
		len = 16'(last_i - start_i + 16'h0001);
		if (en_i && val_i > last_i) begin
			val_o = 16'(val_i - len);
		end else if (en_i && val_i < start_i) begin
			val_o = 16'(val_i + len);
		end else begin
			val_o = val_i;
		end
	end

endmodule

/* File: verilog/operand_address_generation.sv */
// Operand address generator with its working register file.
// Assumes a decoder presents one request per enabled cycle.
//
// Overview of operation
// - File direct takes address from instruction.
// - Register direct uses the register, no memory.
// - Plain indirect uses pointer value unchanged.
// - Post-modify uses pointer, then steps it.
// - Pre-modify steps pointer, then uses it.
// - Indexed uses pointer plus offset register.
// - Literal offset uses pointer plus literal.
// - Only move, accumulator and dual-source accept indexed mode.
// - Move source and destination modes are independent.
// - Move operands share one offset register field.
// - First pair to X, second pair to Y.
// - Dual-source indexed only on second pointers.
// - Dual-source: indirect, indexed, step 2/4/6.
// - Branch target from 16-bit signed literal.
// - Hold count from 14-bit unsigned literal.
// - Implied operands carry no address field.
// - Hardware circular buffer wraps pointer updates.
module operand_address_generation (
	input  wire logic              CLK_I,
	input  wire logic              RESET_I,
	input  wire logic              CE_I,
	input  wire agu_pkg::req_t     REQ_I,
	input  wire logic [15:0]       PC_I,
	input  wire agu_pkg::mod_cfg_t MOD_CFG_I,
	output agu_pkg::mem_t          SRC_O,
	output agu_pkg::mem_t          DST_O,
	output agu_pkg::mem_t          X_O,
	output agu_pkg::mem_t          Y_O,
	output logic [15:0]            SRC_DATA_O,
	output logic                   DONE_O,
	output logic                   ILLEGAL_O,
	output logic                   IMPLIED_O,
	output logic                   BRANCH_O,
	output logic [15:0]            BRANCH_TARGET_O,
	output logic                   HOLD_O,
	output logic [13:0]            HOLD_COUNT_O
);

	// ------------------------------------------------------------------
	// Operand calculation
	// ------------------------------------------------------------------
	// Forms the address, memory flag and pointer update of one operand.
	function automatic agu_pkg::calc_t calc(
		agu_pkg::mode_t    m,
		logic [15:0]       p,
		logic [15:0]       ofs,
		logic signed [4:0] amt,
		logic [15:0]       lit
	);
		agu_pkg::calc_t r;
		logic [15:0]    sa;
		sa = {{11{amt[4]}}, amt};
		r = '0;
		case (m)
			agu_pkg::M_FILE: begin
				r.mem = 1'b1;
				r.ea  = lit;
			end
			agu_pkg::M_IND: begin
				r.mem = 1'b1;
				r.ea  = p;
			end
			agu_pkg::M_POST: begin
				r.mem  = 1'b1;
				r.ea   = p;
				r.newp = 16'(p + sa);
				r.upd  = 1'b1;
			end
			agu_pkg::M_PRE: begin
				r.mem  = 1'b1;
				r.newp = 16'(p + sa);
				r.ea   = r.newp;
				r.upd  = 1'b1;
			end
			agu_pkg::M_IDX: begin
				r.mem = 1'b1;
				r.ea  = 16'(p + ofs);
			end
			agu_pkg::M_LIT: begin
				r.mem = 1'b1;
				r.ea  = 16'(p + lit);
			end
			default: begin
				// Register direct and implied modes make no access.
				r.mem = 1'b0;
			end
		endcase
		return r;
	endfunction

	// Checks one side of a dual-source request against its mode set.
	function automatic logic mac_ok(agu_pkg::mac_opnd_t s);
		logic [4:0] mag;
		logic       ok;
		mag = s.amt[4] ? 5'(-s.amt) : s.amt;
		case (s.mode)
			agu_pkg::M_IND:  ok = 1'b1;
			agu_pkg::M_IDX:  ok = s.sel_b;
			agu_pkg::M_POST: ok = mag == agu_pkg::MAC_STEP2 ||
				mag == agu_pkg::MAC_STEP4 ||
				mag == agu_pkg::MAC_STEP6;
			default:         ok = 1'b0;
		endcase
		return ok;
	endfunction

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	logic [15:0]       rf_reg  [agu_pkg::NREG]; // Working registers.
	logic [15:0]       rf_next [agu_pkg::NREG]; // Their next values.
	agu_pkg::mode_t    sm      [4];  // Mode of each operand slot.
	logic [3:0]        pi      [4];  // Pointer index of each slot.
	logic signed [4:0] am      [4];  // Step amount of each slot.
	logic [3:0]        act;          // Slot takes part in this request.
	agu_pkg::calc_t    cr      [4];  // Raw result of each slot.
	logic [15:0]       wp      [4];  // Wrapped pointer update.
	logic              go;           // Request accepted this cycle.
	logic              bad;          // Request uses a refused mode.
	logic              legal;        // Accepted and allowed.
	logic              gp;           // Class with general operands.
	logic              mac;          // Dual-source class.
	logic [15:0]       src_amt_x;    // Sign-extended source step.

	// ------------------------------------------------------------------
	// Slot setup
	// ------------------------------------------------------------------
	// Slots 0 and 1 are source and destination, 2 and 3 are X and Y.
	always_comb begin
		gp  = REQ_I.cls == agu_pkg::C_ORD || REQ_I.cls == agu_pkg::C_MOVE
			|| REQ_I.cls == agu_pkg::C_ACC;
		mac = REQ_I.cls == agu_pkg::C_MAC;
		// Source and destination decode from their own fields.
		sm[0] = REQ_I.src.mode;
		pi[0] = REQ_I.src.ptr;
		am[0] = REQ_I.src.amt;
		sm[1] = REQ_I.dst.mode;
		pi[1] = REQ_I.dst.ptr;
		am[1] = REQ_I.dst.amt;
		// The pair select reaches only the prefetch pointers.
		sm[2] = REQ_I.mx.mode;
		pi[2] = agu_pkg::X_BASE | {3'b000, REQ_I.mx.sel_b};
		am[2] = REQ_I.mx.amt;
		sm[3] = REQ_I.my.mode;
		pi[3] = agu_pkg::Y_BASE | {3'b000, REQ_I.my.sel_b};
		am[3] = REQ_I.my.amt;
		act = {mac && REQ_I.my.en, mac && REQ_I.mx.en, gp, gp};
		src_amt_x = {{11{REQ_I.src.amt[4]}}, REQ_I.src.amt};
	end

	// Ordinary instructions refuse indexed mode; dual-source sides
	// refuse anything outside their reduced set.
	always_comb begin
		go  = CE_I && REQ_I.valid;
		bad = (REQ_I.cls == agu_pkg::C_ORD &&
			(REQ_I.src.mode == agu_pkg::M_IDX ||
			REQ_I.dst.mode == agu_pkg::M_IDX)) ||
			(act[2] && !mac_ok(REQ_I.mx)) ||
			(act[3] && !mac_ok(REQ_I.my));
		legal = go && !bad;
	end

	// One calculator and one wrap stage per slot; every slot reads the
	// same offset register field.
	for (genvar g = 0; g < 4; g++) begin : g_slot
		assign cr[g] = calc(sm[g], rf_reg[pi[g]],
			rf_reg[REQ_I.off_sel], am[g], REQ_I.lit);
		modulo_wrap u_wrap (
			.en_i    (MOD_CFG_I.en && MOD_CFG_I.ptr == pi[g]),
			.val_i   (cr[g].newp),
			.start_i (MOD_CFG_I.start),
			.last_i  (MOD_CFG_I.last),
			.val_o   (wp[g])
		);
	end

	// ------------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------------
	// Pointer updates land first, in slot order; a register direct
	// destination write comes last and wins over them.
	always_comb begin
		rf_next = rf_reg;
		for (int k = 0; k < 4; k++) begin
			if (act[k] && cr[k].upd) begin
				rf_next[pi[k]] = wp[k];
			end
		end
		if (act[1] && REQ_I.dst.mode == agu_pkg::M_REG) begin
			rf_next[REQ_I.dst.ptr] = REQ_I.wdata;
		end
	end

	// Registers change only on an allowed request.
	always_ff @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			for (int k = 0; k < agu_pkg::NREG; k++) begin
				rf_reg[k] <= agu_pkg::REG_RST;
			end
		end else if (legal) begin
			rf_reg <= rf_next;
		end
	end

	// ------------------------------------------------------------------
	// Memory requests
	// ------------------------------------------------------------------
	// Address outputs for each slot, one cycle after acceptance.
	always_ff @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			SRC_O <= '0;
			DST_O <= '0;
			X_O   <= '0;
			Y_O   <= '0;
		end else if (CE_I) begin
			SRC_O <= '{legal && act[0] && cr[0].mem, cr[0].ea};
			DST_O <= '{legal && act[1] && cr[1].mem, cr[1].ea};
			X_O   <= '{legal && act[2], cr[2].ea};
			Y_O   <= '{legal && act[3], cr[3].ea};
		end
	end

	// ------------------------------------------------------------------
	// Status and literal decode
	// ------------------------------------------------------------------
	// Request status and register direct source data.
	always_ff @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			DONE_O     <= 1'b0;
			ILLEGAL_O  <= 1'b0;
			IMPLIED_O  <= 1'b0;
			SRC_DATA_O <= agu_pkg::REG_RST;
		end else if (CE_I) begin
			DONE_O    <= go;
			ILLEGAL_O <= go && bad;
			IMPLIED_O <= legal && gp &&
				(sm[0] == agu_pkg::M_IMPL || sm[1] == agu_pkg::M_IMPL);
			if (legal && gp && sm[0] == agu_pkg::M_REG) begin
				SRC_DATA_O <= rf_reg[REQ_I.src.ptr];
			end
		end
	end

	// Branch target and interrupt hold count from the literal field.
	always_ff @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			BRANCH_O        <= 1'b0;
			BRANCH_TARGET_O <= 16'h0000;
			HOLD_O          <= 1'b0;
			HOLD_COUNT_O    <= 14'h0000;
		end else if (CE_I) begin
			BRANCH_O <= go && REQ_I.cls == agu_pkg::C_BRA;
			HOLD_O   <= go && REQ_I.cls == agu_pkg::C_HOLD;
			if (go && REQ_I.cls == agu_pkg::C_BRA) begin
				// The signed literal wraps modulo 2^16 on the add.
				BRANCH_TARGET_O <= 16'(PC_I + REQ_I.lit);
			end
			if (go && REQ_I.cls == agu_pkg::C_HOLD) begin
				HOLD_COUNT_O <= REQ_I.lit[agu_pkg::HOLD_W-1:0];
			end
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RESET_I);

	logic s_ok; // Source slot allowed with nothing else on its pointer.
	assign s_ok = legal && gp && REQ_I.dst.mode == agu_pkg::M_IMPL;

	file_addr_a: assert property (s_ok && sm[0] == agu_pkg::M_FILE
		|=> SRC_O.en && SRC_O.ea == $past(REQ_I.lit))
		else $error("file direct address wrong");
	reg_direct_a: assert property (s_ok && sm[0] == agu_pkg::M_REG
		|=> !SRC_O.en && SRC_DATA_O == $past(rf_reg[REQ_I.src.ptr]))
		else $error("register direct operand wrong");
	plain_ind_a: assert property (s_ok && sm[0] == agu_pkg::M_IND
		|=> SRC_O.ea == $past(rf_reg[REQ_I.src.ptr]) ##1 1'b1)
		else $error("plain indirect address wrong");
	post_mod_a: assert property (s_ok && sm[0] == agu_pkg::M_POST
		|=> SRC_O.ea == $past(rf_reg[REQ_I.src.ptr]))
		else $error("post-modify used stepped pointer");
	pre_mod_a: assert property (s_ok && sm[0] == agu_pkg::M_PRE
		&& !MOD_CFG_I.en
		|=> SRC_O.ea == $past(16'(rf_reg[REQ_I.src.ptr] + src_amt_x)))
		else $error("pre-modify address wrong");
	indexed_a: assert property (s_ok && sm[0] == agu_pkg::M_IDX
		|=> SRC_O.ea == $past(16'(rf_reg[REQ_I.src.ptr] +
		rf_reg[REQ_I.off_sel])))
		else $error("indexed address wrong");
	lit_offset_a: assert property (s_ok && sm[0] == agu_pkg::M_LIT
		|=> SRC_O.ea == $past(16'(rf_reg[REQ_I.src.ptr] + REQ_I.lit)))
		else $error("literal offset address wrong");
	dst_index_a: assert property (legal && REQ_I.cls == agu_pkg::C_MOVE
		&& sm[1] == agu_pkg::M_IDX
		|=> DST_O.en && DST_O.ea == $past(16'(rf_reg[REQ_I.dst.ptr] +
		rf_reg[REQ_I.off_sel])))
		else $error("destination indexed address wrong");
	ord_index_a: assert property (go && REQ_I.cls == agu_pkg::C_ORD
		&& sm[0] == agu_pkg::M_IDX |=> ILLEGAL_O && !SRC_O.en)
		else $error("ordinary indexed not refused");
	x_route_a: assert property (legal && act[2] && !REQ_I.mx.sel_b
		&& sm[2] == agu_pkg::M_IND
		|=> X_O.en && X_O.ea == $past(rf_reg[agu_pkg::X_BASE]))
		else $error("X pointer not routed");
	mac_index_a: assert property (go && act[2] && !REQ_I.mx.sel_b
		&& sm[2] == agu_pkg::M_IDX |=> ILLEGAL_O && !X_O.en)
		else $error("indexed on first X pointer");
	mac_step_a: assert property (go && act[3]
		&& sm[3] == agu_pkg::M_PRE |=> ILLEGAL_O && !Y_O.en)
		else $error("dual-source pre-modify accepted");
	branch_lit_a: assert property (go && REQ_I.cls == agu_pkg::C_BRA
		|=> BRANCH_O && BRANCH_TARGET_O == $past(16'(PC_I + REQ_I.lit)))
		else $error("branch target wrong");
	hold_count_a: assert property (go && REQ_I.cls == agu_pkg::C_HOLD
		|=> HOLD_O && HOLD_COUNT_O == $past(REQ_I.lit[13:0]))
		else $error("hold count wrong");
	implied_a: assert property (s_ok && sm[0] == agu_pkg::M_IMPL
		|=> IMPLIED_O && !SRC_O.en)
		else $error("implied operand made access");
	wrap_a: assert property (s_ok && sm[0] == agu_pkg::M_POST &&
		MOD_CFG_I.en && MOD_CFG_I.ptr == pi[0] &&
		MOD_CFG_I.start <= MOD_CFG_I.last
		|=> rf_reg[$past(pi[0])] <= $past(MOD_CFG_I.last))
		else $error("circular pointer left buffer");
	write_back_a: assert property (s_ok && sm[0] == agu_pkg::M_POST
		&& !MOD_CFG_I.en |=> rf_reg[$past(pi[0])] ==
		$past(16'(rf_reg[REQ_I.src.ptr] + src_amt_x)))
		else $error("pointer not written back");

	post_cov: cover property (s_ok && sm[0] == agu_pkg::M_POST);
	dual_cov: cover property (legal && act[2] && act[3]);
	wrap_cov: cover property (legal && MOD_CFG_I.en && wp[0] != cr[0].newp);
	bra_cov:  cover property (go && REQ_I.cls == agu_pkg::C_BRA);

endmodule

/* File: tb/data_space_model.sv */
// Model of the X and Y data spaces read by the dual-source generators.
// Assumes space bounds as parameters; the defaults are plain picks.
module data_space_model #(
	parameter logic [15:0] X_LO = 16'h0800, // Lowest X address.
	parameter logic [15:0] X_HI = 16'h17FF, // Highest X address.
	parameter logic [15:0] Y_LO = 16'h8800, // Lowest Y address.
	parameter logic [15:0] Y_HI = 16'h97FF  // Highest Y address.
) (
	input  wire logic          clk_i,
	input  wire agu_pkg::mem_t x_i,
	input  wire agu_pkg::mem_t y_i,
	output logic [15:0]        stray_o
);
	timeunit 1ns;
	timeprecision 100ps;

	logic x_bad; // X read outside X space.
	logic y_bad; // Y read outside Y space.

	assign x_bad = x_i.en && (x_i.ea < X_LO || x_i.ea > X_HI);
	assign y_bad = y_i.en && (y_i.ea < Y_LO || y_i.ea > Y_HI);

	// Counts reads that land outside the space of their generator.
	// The read strobes are unknown until the first reset edge, so only
	// a definite stray read is counted.
	initial stray_o = 16'h0000;
	always @(posedge clk_i) begin
		if (x_bad || y_bad) begin
			stray_o <= stray_o + {15'h0000, x_bad} + {15'h0000, y_bad};
		end
	end
endmodule

/* File: tb/operand_address_generation_tb.sv */
// Self-checking bench of the operand address generator.
// Assumes one answer per enabled request, read 1 ns after the edge that samples it.
module operand_address_generation_tb;
	timeunit 1ns;
	timeprecision 100ps;

	// ---------------------------------------------------------------
	// Signals and model state
	// ---------------------------------------------------------------
	logic               clk_i = 1'b0;
	logic               reset_i = 1'b1;
	logic               ce_i = 1'b1;
	agu_pkg::req_t      req_i = '0;
	logic [15:0]        pc_i = 16'h0000;
	agu_pkg::mod_cfg_t  cfg = '0;
	agu_pkg::mem_t      src_o, dst_o, x_o, y_o;
	logic [15:0]        src_data_o, branch_target_o, stray;
	logic               done_o, illegal_o, implied_o, branch_o, hold_o;
	logic [13:0]        hold_count_o;
	logic [15:0]        rf [16];     // Expected working registers.
	int                 mismatches = 0;
	int                 num_checks = 0;
	int                 cycles = 0;
	integer             seed;
	agu_pkg::req_t      r;

	operand_address_generation i_dut (
		.CLK_I(clk_i), .RESET_I(reset_i), .CE_I(ce_i), .REQ_I(req_i),
		.PC_I(pc_i), .MOD_CFG_I(cfg), .SRC_O(src_o), .DST_O(dst_o),
		.X_O(x_o), .Y_O(y_o), .SRC_DATA_O(src_data_o), .DONE_O(done_o),
		.ILLEGAL_O(illegal_o), .IMPLIED_O(implied_o),
		.BRANCH_O(branch_o), .BRANCH_TARGET_O(branch_target_o),
		.HOLD_O(hold_o), .HOLD_COUNT_O(hold_count_o));

	data_space_model i_mem (.clk_i(clk_i), .x_i(x_o), .y_i(y_o),
		.stray_o(stray));

	// Free-running clock; a hang is cut short by the cycle ceiling.
	always #12.5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			close_out();
		end
	end

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	// Counts one comparison and reports it when it fails.
	task automatic chk(input logic ok, input string what);
		num_checks++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("mismatch at %0t: %s", $time, what);
		end
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	function automatic int rnd(input int n);
		return $unsigned($random(seed)) % n;
	endfunction

	// Circular buffer correction of an updated pointer.
	function automatic logic [15:0] wrap(input logic [3:0] p,
			input logic [15:0] v);
		logic [15:0] sz;
		sz = cfg.last - cfg.start + 16'h0001;
		if (cfg.en && p == cfg.ptr && v > cfg.last) return v - sz;
		if (cfg.en && p == cfg.ptr && v < cfg.start) return v + sz;
		return v;
	endfunction

	// True when a dual-source side asks only for an offered mode.
	function automatic logic mac_ok(input agu_pkg::mac_opnd_t s);
		logic [4:0] a;
		a = s.amt[4] ? -s.amt : s.amt;
		return !s.en || s.mode == agu_pkg::M_IND ||
			(s.mode == agu_pkg::M_POST && (a == agu_pkg::MAC_STEP2 ||
			a == agu_pkg::MAC_STEP4 || a == agu_pkg::MAC_STEP6)) ||
			(s.mode == agu_pkg::M_IDX && s.sel_b);
	endfunction

	// Expected access and pointer update of one operand slot.
	task automatic calc(input agu_pkg::opnd_t o, input logic [3:0] off,
			input logic [15:0] lit, output agu_pkg::mem_t m,
			output logic u, output logic [15:0] n);
		logic [15:0] p, s;
		p = rf[o.ptr];
		s = p + {{11{o.amt[4]}}, o.amt};
		m = '0;
		u = 1'b0;
		n = p;
		case (o.mode)
			agu_pkg::M_FILE: m = '{1'b1, lit};
			agu_pkg::M_IND:  m = '{1'b1, p};
			agu_pkg::M_POST: begin
				m = '{1'b1, p};
				u = 1'b1;
				n = wrap(o.ptr, s);
			end
			agu_pkg::M_PRE:  begin
				m = '{1'b1, s};
				u = 1'b1;
				n = wrap(o.ptr, s);
			end
			agu_pkg::M_IDX:  m = '{1'b1, p + rf[off]};
			agu_pkg::M_LIT:  m = '{1'b1, p + lit};
			default: ;
		endcase
	endtask

	// Drives one request, predicts its answer and compares it.
	task automatic send(input agu_pkg::req_t q);
		agu_pkg::mem_t  es, ed, ex, ey;
		agu_pkg::opnd_t ox, oy;
		logic [15:0]    ns, nd, nx, ny, sv;
		logic           us, ud, ux, uy, ill, imp, sdv, wr;
		{es, ed, ex, ey, us, ud, ux, uy, ill, imp, sdv, wr} = '0;
		ox = '{q.mx.mode, agu_pkg::X_BASE | {3'h0, q.mx.sel_b}, q.mx.amt};
		oy = '{q.my.mode, agu_pkg::Y_BASE | {3'h0, q.my.sel_b}, q.my.amt};
		sv = rf[q.src.ptr];
		if (q.valid && q.cls == agu_pkg::C_MAC) begin
			ill = !mac_ok(q.mx) || !mac_ok(q.my);
			if (!ill && q.mx.en) calc(ox, q.off_sel, q.lit, ex, ux, nx);
			if (!ill && q.my.en) calc(oy, q.off_sel, q.lit, ey, uy, ny);
		end else if (q.valid && !(q.cls inside {agu_pkg::C_BRA,
				agu_pkg::C_HOLD})) begin
			ill = q.cls == agu_pkg::C_ORD && (q.src.mode == agu_pkg::M_IDX
				|| q.dst.mode == agu_pkg::M_IDX);
			imp = q.src.mode == agu_pkg::M_IMPL ||
				q.dst.mode == agu_pkg::M_IMPL;
			if (!ill) begin
				calc(q.src, q.off_sel, q.lit, es, us, ns);
				calc(q.dst, q.off_sel, q.lit, ed, ud, nd);
				sdv = q.src.mode == agu_pkg::M_REG;
				wr = q.dst.mode == agu_pkg::M_REG;
			end
		end
		if (us) rf[q.src.ptr] = ns;
		if (ud) rf[q.dst.ptr] = nd;
		if (ux) rf[ox.ptr] = nx;
		if (uy) rf[oy.ptr] = ny;
		if (wr) rf[q.dst.ptr] = q.wdata;
		req_i = q;
		@(posedge clk_i);
		#1;
		chk(done_o === q.valid, "done pulse");
		chk(illegal_o === ill, "refusal flag");
		chk(src_o.en === es.en && (!es.en || src_o.ea === es.ea),
			"source access");
		chk(dst_o.en === ed.en && (!ed.en || dst_o.ea === ed.ea),
			"destination access");
		chk(x_o.en === ex.en && (!ex.en || x_o.ea === ex.ea),
			"X read");
		chk(y_o.en === ey.en && (!ey.en || y_o.ea === ey.ea),
			"Y read");
		if (q.valid && !ill) chk(implied_o === imp, "implied");
		if (sdv) chk(src_data_o === sv, "register source");
		chk(branch_o === (q.valid && q.cls == agu_pkg::C_BRA), "bra");
		chk(hold_o === (q.valid && q.cls == agu_pkg::C_HOLD), "hold");
		if (q.valid && q.cls == agu_pkg::C_BRA) begin
			chk(branch_o === 1'b1 && branch_target_o === pc_i + q.lit,
				"branch target");
		end
		if (q.valid && q.cls == agu_pkg::C_HOLD) begin
			chk(hold_o === 1'b1 && hold_count_o === q.lit[13:0],
				"hold count");
		end
	endtask

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		agu_pkg::mode_t sm [8] = '{agu_pkg::M_FILE, agu_pkg::M_REG,
			agu_pkg::M_IND, agu_pkg::M_POST, agu_pkg::M_PRE,
			agu_pkg::M_IDX, agu_pkg::M_LIT, agu_pkg::M_IMPL};
		agu_pkg::cls_t  cl [3] = '{agu_pkg::C_ORD, agu_pkg::C_MOVE,
			agu_pkg::C_ACC};
		logic [4:0]     ma [7] = '{5'h02, 5'h1E, 5'h04, 5'h1C, 5'h06,
			5'h1A, 5'h03};
		seed = 32'hf595;
		foreach (rf[k]) rf[k] = agu_pkg::REG_RST;
		// Reset for three cycles; the done, source and X outputs must sit at zero.
		repeat (3) @(posedge clk_i);
		#1;
		chk(done_o === 1'b0 && src_o === '0 && x_o === '0, "reset");
		reset_i = 1'b0;
		// Load every register, reading its reset value on the way.
		for (int k = 0; k < 16; k++) begin
			r = '0;
			r.valid = 1'b1;
			r.cls = agu_pkg::C_MOVE;
			r.src = '{agu_pkg::M_REG, 4'(k), 5'h00};
			r.dst = '{agu_pkg::M_REG, 4'(k), 5'h00};
			r.wdata = (k == 8 || k == 9) ? 16'h1000 :
				(k == 10 || k == 11) ? 16'h9000 :
				(k == 12) ? 16'h0010 : 16'($random(seed));
			send(r);
		end
		// Random ordinary, move and accumulator requests back to back.
		for (int i = 0; i < 80; i++) begin
			r = '0;
			r.valid = 1'b1;
			r.cls = cl[rnd(3)];
			r.src = '{sm[rnd(8)], 4'(rnd(4)), 5'($random(seed))};
			r.dst = '{sm[rnd(8)], 4'(4 + rnd(4)), 5'($random(seed))};
			r.off_sel = 4'(rnd(8));
			r.lit = 16'($random(seed));
			r.wdata = 16'($random(seed));
			send(r);
		end
		// Dual-source requests on the four prefetch pointers only.
		for (int i = 0; i < 50; i++) begin
			r = '0;
			r.valid = 1'b1;
			r.cls = agu_pkg::C_MAC;
			r.off_sel = 4'hC;
			r.mx = '{1'(rnd(2)), 1'(rnd(2)), sm[2 + rnd(4)], ma[rnd(7)]};
			r.my = '{1'(rnd(2)), 1'(rnd(2)), sm[2 + rnd(4)], ma[rnd(7)]};
			send(r);
		end
		// Branch and hold literals, the extremes first.
		for (int i = 0; i < 8; i++) begin
			r = '0;
			r.valid = 1'b1;
			r.cls = i[0] ? agu_pkg::C_HOLD : agu_pkg::C_BRA;
			r.lit = (i < 2) ? 16'hFFFF - 16'(i) * 16'h7FFF :
				16'($random(seed));
			pc_i = 16'($random(seed));
			send(r);
		end
		// Circular buffer: step past each end of an eight-byte ring.
		cfg = '{1'b1, 4'h3, 16'h1000, 16'h1007};
		r = '0;
		r.valid = 1'b1;
		r.cls = agu_pkg::C_MOVE;
		r.dst = '{agu_pkg::M_REG, 4'h3, 5'h00};
		r.wdata = 16'h1006;
		send(r);
		r.dst = '{agu_pkg::M_IMPL, 4'h7, 5'h00};
		r.src = '{agu_pkg::M_POST, 4'h3, 5'h02};
		send(r);
		r.src = '{agu_pkg::M_PRE, 4'h3, 5'h1E};
		send(r);
		r.src = '{agu_pkg::M_REG, 4'h3, 5'h00};
		send(r);
		cfg = '0;
		// A low enable freezes the pulses and ignores the request.
		r = '0;
		r.valid = 1'b1;
		r.cls = agu_pkg::C_BRA;
		ce_i = 1'b0;
		req_i = r;
		@(posedge clk_i);
		#1;
		chk(done_o === 1'b1 && branch_o === 1'b0, "frozen outputs");
		ce_i = 1'b1;
		send('0);
		chk(stray === 16'h0000, "data space");
		close_out();
	end
endmodule
